// ### design/rbfe_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the receiver front-end register bank
// Assumes: Byte addresses on the local register port; data in the low byte
// Notes: Definitions only
`ifndef RBFE_DEFINES_SVH
`define RBFE_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define RBFE_OFS_CLR1 8'h00
`define RBFE_OFS_CLR0 8'h04
`define RBFE_OFS_CLR2 8'h08
`define RBFE_OFS_LVL0 8'h10
`define RBFE_OFS_LVL1 8'h14
`define RBFE_OFS_LVL2 8'h18
`define RBFE_OFS_FECLR 8'h20
`define RBFE_OFS_STAT 8'h24
`define RBFE_OFS_ERR 8'h28
`define RBFE_OFS_MODE 8'h2C
`define RBFE_OFS_MASK 8'h30
`define RBFE_OFS_BSYEN 8'h34

// ****************************************
// Fields, reset values, codes
// ****************************************
`define RBFE_MODE_BIT 0
`define RBFE_BSYEN_BIT 0
`define RBFE_MODE_RST 1'b0
`define RBFE_BSYEN_RST 1'b0
`define RBFE_MASK_VAL 8'hFF
`define RBFE_HDR_LEN 7'h40
`define RBFE_PED_BYTE 7'h10
`define RBFE_GATE_STAT 2'h1
`define RBFE_GATE_ERR 2'h2
`define RBFE_GATE_SPARE 2'h3
`define RBFE_SPARE_VAL 8'h00

// ****************************************
// Timing
// ****************************************
`define RBFE_CLK_MHZ 125
`define RBFE_WDOG_US 1000

`endif

// ### design/rbfe_pkg.sv
// Purpose: Types shared by the receiver front-end register bank
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: Constants live in rbfe_defines.svh
package rbfe_pkg;

	// Front-end framing events, one-cycle pulses
	typedef struct packed {
		logic hdr_start;
		logic evt_start;
		logic hdr_end;
		logic evt_end;
		logic link_err;
	} rbfe_evt_s;

	// Word from the deserialiser
	typedef struct packed {
		logic valid;
		logic is_hdr;
		logic [1:0] dest;
		logic [2:0] strb;
		logic [19:0] data;
	} rbfe_word_s;

	// Per-mezzanine data path
	typedef struct packed {
		logic [19:0] data;
		logic [2:0] strb;
	} rbfe_mezz_s;

	// Abort pulse generator, one-hot
	typedef enum logic [2:0] {
		RBFE_AB_IDLE = 3'b001,
		RBFE_AB_LOW1 = 3'b010,
		RBFE_AB_LOW2 = 3'b100
	} rbfe_abort_e;

endpackage : rbfe_pkg

// ### design/rbfe_regs.sv
// Purpose: Busy, front-end control/status registers and mezzanine sideband of the fiber receiver
// Assumes: One 125 MHz clock; all inputs synchronous to it
// Notes: Header bytes pass through an 8-word buffer on their way to the header memory
//
// Function
// - Write to clear-busy register n clears only mezzanine n busy flag.
// - Clear-busy registers read all three busy flags in bits 0..2.
// - Level-busy write n sets or clears only mezzanine n soft busy.
// - Level-busy registers read all three soft busy flags in bits 0..2.
// - Any write to front-end clear resets the front end.
// - Clearing the last busy flag also resets the front end.
// - Status: link ready, busy, spares zero, full event, event start, header start.
// - Errors: link, overrun, end missing, header length not 64, spares zero.
// - Mode bit 0: 1 silicon, 0 drift; resets 0; silicon enables pedestal strobe.
// - Busy-output enable bit 0 gates the busy output; reset disables.
// - Abort pulse is active low, two clocks, on request while ready or reset.
// - Active-low end-of-event level holds until front-end clear.
// - Each mezzanine gets a 20-bit data bus and three strobes.
// - Pedestal strobe marks header byte 16, duplicated on both word halves.
// - Active-low fault interrupt ORs latched faults; cleared by front-end clear or abort.
// - Watchdog starts at event end; expiry without front-end clear latches a fault.
// - Header bytes go out with active-low enable, strobe and 10-bit bus.
// - Header-done level sets at header end, clears on front-end clear.
// - Read gate 01 status, 10 errors, 11 spare register.
// - Drift mode line is the inverse of the mode bit.
// - Reset disables busy output, selects drift mode, clears flags and front end.
// - Registers hold up to eight bits in the low byte on aligned words.
`timescale 1ns/1ns
`include "rbfe_defines.svh"
`default_nettype none

// ****************************************
// Header byte buffer
// ****************************************
module rbfe_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0] count_ff, nxt_count;
	logic push, pop;

	// Ready and valid come from the count so full and empty are exact
	assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign out_data_o = mem_ff[rd_ptr_ff];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Pointer and count update
	always_comb begin
		nxt_wr_ptr = push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
		nxt_rd_ptr = pop ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
		nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Storage needs no reset
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
	end
endmodule : rbfe_fifo

// ****************************************
// Register bank and front-end sideband
// ****************************************
module rbfe_regs #(
	parameter int WDOG_CYCLES = `RBFE_WDOG_US * `RBFE_CLK_MHZ,
	parameter int HDR_DEPTH = 8
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Local register port
	input wire logic [7:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [31:0] bus_wdata_i,
	output logic [31:0] bus_rdata_o,
	// Deserialiser side
	input wire logic link_ready_i,
	input wire rbfe_pkg::rbfe_evt_s evt_i,
	input wire rbfe_pkg::rbfe_word_s word_i,
	output logic word_ready_o,
	input wire logic abort_req_i,
	// Mezzanine side
	output rbfe_pkg::rbfe_mezz_s [2:0] mezz_bus_o,
	output logic pedestal_strobe_o,
	output logic abort_pulse_n_o,
	output logic event_end_n_o,
	output logic fault_irq_n_o,
	output logic event_end_watchdog_n_o,
	input wire logic [1:0] frontend_read_gate_i,
	output logic [7:0] frontend_reg_o,
	// Header memory side
	input wire logic hdr_mem_ready_i,
	output logic hdr_serial_en_n_o,
	output logic hdr_serial_strobe_o,
	output logic [9:0] latched_header_bus_o,
	output logic header_done_o,
	output logic hdr_mask_init_o,
	// Board level
	output logic frontend_clear_o,
	output logic drift_mode_line_o,
	output logic busy_out_o
);
	// Register state
	logic [2:0] clear_flag_ff, nxt_clear_flag;
	logic [2:0] level_flag_ff, nxt_level_flag;
	logic mode_ff, nxt_mode;
	logic busy_out_on_ff, nxt_busy_out_on;
	logic [31:0] rdata_ff, nxt_rdata;
	// Front-end state
	logic busy_ff, nxt_busy, full_evt_ff, nxt_full_evt, evt_seen_ff, nxt_evt_seen, hdr_seen_ff, nxt_hdr_seen;
	logic link_fault_ff, nxt_link_fault, overrun_fault_ff, nxt_overrun_fault;
	logic end_missing_fault_ff, nxt_end_missing_fault, header_length_fault_ff, nxt_header_length_fault;
	logic eoe_ff, nxt_eoe, hdr_done_ff, nxt_hdr_done, wdog_run_ff, nxt_wdog_run;
	logic [31:0] wdog_cnt_ff, nxt_wdog_cnt;
	logic [6:0] hdr_cnt_ff, nxt_hdr_cnt;
	rbfe_pkg::rbfe_abort_e ab_ff, nxt_ab;
	// Output flops
	rbfe_pkg::rbfe_mezz_s [2:0] mezz_ff, nxt_mezz;
	logic ped_ff, nxt_ped, hdr_serial_en_n_n_ff, nxt_hdr_serial_en_n_n, ser_stb_ff, nxt_ser_stb;
	logic [9:0] lhd_ff, nxt_lhd;
	logic mask_ff, nxt_mask, feclr_ff, fault_n_ff, nxt_fault_n, busy_out_ff, nxt_busy_out;
	logic [7:0] fe_reg_ff, nxt_fe_reg;
	// Internal
	logic [7:0] status_byte, error_byte;
	logic wr_clr, frontend_clear_sig, abort_now, hdr_push, fifo_ready, fifo_valid;
	logic [9:0] fifo_data;

	// Write decode; a clear that empties the last flag is an automatic front-end clear
	always_comb begin
		nxt_clear_flag = clear_flag_ff;
		nxt_level_flag = level_flag_ff;
		nxt_mode = mode_ff;
		nxt_busy_out_on = busy_out_on_ff;
		nxt_mask = 1'b0;
		wr_clr = 1'b0;
		if (bus_wr_i) begin
			case (bus_addr_i)
				`RBFE_OFS_CLR0: nxt_clear_flag[0] = 1'b0;
				`RBFE_OFS_CLR1: nxt_clear_flag[1] = 1'b0;
				`RBFE_OFS_CLR2: nxt_clear_flag[2] = 1'b0;
				`RBFE_OFS_LVL0: nxt_level_flag[0] = bus_wdata_i[0];
				`RBFE_OFS_LVL1: nxt_level_flag[1] = bus_wdata_i[1];
				`RBFE_OFS_LVL2: nxt_level_flag[2] = bus_wdata_i[2];
				`RBFE_OFS_FECLR: wr_clr = 1'b1;
				`RBFE_OFS_MODE: nxt_mode = bus_wdata_i[`RBFE_MODE_BIT];
				`RBFE_OFS_MASK: nxt_mask = (bus_wdata_i[7:0] == `RBFE_MASK_VAL);
				`RBFE_OFS_BSYEN: nxt_busy_out_on = bus_wdata_i[`RBFE_BSYEN_BIT];
				default: nxt_mask = 1'b0;
			endcase
		end
		frontend_clear_sig = wr_clr | ((clear_flag_ff != 3'h0) & (nxt_clear_flag == 3'h0));
		// An event end sets every busy flag and wins over a same-cycle clear
		if (evt_i.evt_end) begin
			nxt_clear_flag = 3'h7;
		end
	end

	// Status and error bytes; spare bits read zero
	assign status_byte = {link_ready_i, busy_ff, 3'h0, full_evt_ff, evt_seen_ff, hdr_seen_ff};
	assign error_byte = {link_fault_ff, overrun_fault_ff, end_missing_fault_ff, header_length_fault_ff, 4'h0};

	// Read mux; upper bytes and unmapped offsets read zero
	always_comb begin
		nxt_rdata = rdata_ff;
		if (bus_rd_i) begin
			case (bus_addr_i)
				`RBFE_OFS_CLR0, `RBFE_OFS_CLR1, `RBFE_OFS_CLR2: nxt_rdata = {29'h0, clear_flag_ff};
				`RBFE_OFS_LVL0, `RBFE_OFS_LVL1, `RBFE_OFS_LVL2: nxt_rdata = {29'h0, level_flag_ff};
				`RBFE_OFS_STAT: nxt_rdata = {24'h0, status_byte};
				`RBFE_OFS_ERR: nxt_rdata = {24'h0, error_byte};
				`RBFE_OFS_MODE: nxt_rdata = {31'h0, mode_ff};
				`RBFE_OFS_BSYEN: nxt_rdata = {31'h0, busy_out_on_ff};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	// Abort: two low cycles on request while the link is ready, and once after reset
	assign abort_now = (ab_ff != rbfe_pkg::RBFE_AB_IDLE);
	always_comb begin
		case (ab_ff)
			rbfe_pkg::RBFE_AB_IDLE: nxt_ab = (abort_req_i & link_ready_i) ? rbfe_pkg::RBFE_AB_LOW1
				: rbfe_pkg::RBFE_AB_IDLE;
			rbfe_pkg::RBFE_AB_LOW1: nxt_ab = rbfe_pkg::RBFE_AB_LOW2;
			rbfe_pkg::RBFE_AB_LOW2: nxt_ab = rbfe_pkg::RBFE_AB_IDLE;
			default: nxt_ab = rbfe_pkg::RBFE_AB_IDLE;
		endcase
	end

	// Front-end framing, fault latches and watchdog; new events win over a clear
	always_comb begin
		nxt_busy = busy_ff;
		nxt_full_evt = full_evt_ff;
		nxt_evt_seen = evt_seen_ff;
		nxt_hdr_seen = hdr_seen_ff;
		nxt_eoe = eoe_ff;
		nxt_hdr_done = hdr_done_ff;
		nxt_link_fault = link_fault_ff;
		nxt_overrun_fault = overrun_fault_ff;
		nxt_end_missing_fault = end_missing_fault_ff;
		nxt_header_length_fault = header_length_fault_ff;
		nxt_wdog_run = wdog_run_ff;
		nxt_wdog_cnt = wdog_cnt_ff;
		nxt_hdr_cnt = hdr_cnt_ff;
		if (frontend_clear_sig) begin
			// Mezzanines are expected to have acknowledged any fault by now
			nxt_busy = 1'b0;
			nxt_full_evt = 1'b0;
			nxt_evt_seen = 1'b0;
			nxt_hdr_seen = 1'b0;
			nxt_eoe = 1'b0;
			nxt_hdr_done = 1'b0;
			nxt_wdog_run = 1'b0;
		end
		if (frontend_clear_sig | abort_now) begin
			nxt_link_fault = 1'b0;
			nxt_overrun_fault = 1'b0;
			nxt_end_missing_fault = 1'b0;
			nxt_header_length_fault = 1'b0;
		end
		if (evt_i.hdr_start) begin
			nxt_hdr_seen = 1'b1;
			nxt_hdr_cnt = 7'h0;
		end else if (hdr_push) begin
			nxt_hdr_cnt = hdr_cnt_ff + 7'h1;
		end
		if (evt_i.evt_start) begin
			nxt_overrun_fault = overrun_fault_ff | busy_ff;
			nxt_busy = 1'b1;
			nxt_evt_seen = 1'b1;
		end
		if (evt_i.hdr_end) begin
			nxt_hdr_done = 1'b1;
			nxt_header_length_fault = (hdr_cnt_ff != `RBFE_HDR_LEN) | header_length_fault_ff;
		end
		if (evt_i.link_err) begin
			nxt_link_fault = 1'b1;
		end
		if (evt_i.evt_end) begin
			nxt_full_evt = 1'b1;
			nxt_eoe = 1'b1;
			nxt_wdog_run = 1'b1;
			nxt_wdog_cnt = 32'h0;
		end else if (wdog_run_ff) begin
			if (wdog_cnt_ff == 32'(WDOG_CYCLES - 1)) begin
				nxt_end_missing_fault = 1'b1;
				nxt_wdog_run = 1'b0;
			end else begin
				nxt_wdog_cnt = wdog_cnt_ff + 32'h1;
			end
		end
	end

	// Header bytes queue toward the serial memory port; a full buffer stalls the source
	assign hdr_push = word_i.valid & word_i.is_hdr & fifo_ready;
	rbfe_fifo #(
		.WIDTH(10),
		.DEPTH(HDR_DEPTH)
	) u_hdr_fifo (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(word_i.valid & word_i.is_hdr),
		.in_data_i(word_i.data[9:0]),
		.in_ready_o(fifo_ready),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(hdr_mem_ready_i)
	);

	// Mezzanine data, pedestal, header port and gated readback
	always_comb begin
		nxt_mezz = '0;
		for (int m = 0; m < 3; m++) begin
			if (word_i.valid & ~word_i.is_hdr & (word_i.dest == 2'(m))) begin
				nxt_mezz[m].data = word_i.data;
				nxt_mezz[m].strb = word_i.strb;
			end
		end
		nxt_ped = 1'b0;
		if (mode_ff & hdr_push & (hdr_cnt_ff == `RBFE_PED_BYTE)) begin
			nxt_ped = 1'b1;
			for (int m = 0; m < 3; m++) begin
				nxt_mezz[m].data = {word_i.data[9:0], word_i.data[9:0]};
			end
		end
		nxt_ser_stb = fifo_valid & hdr_mem_ready_i;
		nxt_hdr_serial_en_n_n = ~(fifo_valid & hdr_mem_ready_i);
		nxt_lhd = (fifo_valid & hdr_mem_ready_i) ? fifo_data : lhd_ff;
		nxt_fault_n = ~(nxt_link_fault | nxt_overrun_fault | nxt_end_missing_fault
			| nxt_header_length_fault);
		nxt_busy_out = busy_out_on_ff & (busy_ff | (|clear_flag_ff) | (|level_flag_ff));
		case (frontend_read_gate_i)
			`RBFE_GATE_STAT: nxt_fe_reg = status_byte;
			`RBFE_GATE_ERR: nxt_fe_reg = error_byte;
			`RBFE_GATE_SPARE: nxt_fe_reg = `RBFE_SPARE_VAL;
			default: nxt_fe_reg = 8'h00;
		endcase
	end

	// All state registers; reset restores the documented defaults
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_flag_ff <= 3'h0;
			level_flag_ff <= 3'h0;
			mode_ff <= `RBFE_MODE_RST;
			busy_out_on_ff <= `RBFE_BSYEN_RST;
			rdata_ff <= 32'h0;
			busy_ff <= 1'b0;
			full_evt_ff <= 1'b0;
			evt_seen_ff <= 1'b0;
			hdr_seen_ff <= 1'b0;
			link_fault_ff <= 1'b0;
			overrun_fault_ff <= 1'b0;
			end_missing_fault_ff <= 1'b0;
			header_length_fault_ff <= 1'b0;
			eoe_ff <= 1'b0;
			hdr_done_ff <= 1'b0;
			wdog_run_ff <= 1'b0;
			wdog_cnt_ff <= 32'h0;
			hdr_cnt_ff <= 7'h0;
			ab_ff <= rbfe_pkg::RBFE_AB_LOW1;
			mezz_ff <= '0;
			ped_ff <= 1'b0;
			hdr_serial_en_n_n_ff <= 1'b1;
			ser_stb_ff <= 1'b0;
			lhd_ff <= 10'h0;
			mask_ff <= 1'b0;
			feclr_ff <= 1'b0;
			fault_n_ff <= 1'b1;
			busy_out_ff <= 1'b0;
			fe_reg_ff <= 8'h00;
		end else begin
			clear_flag_ff <= nxt_clear_flag;
			level_flag_ff <= nxt_level_flag;
			mode_ff <= nxt_mode;
			busy_out_on_ff <= nxt_busy_out_on;
			rdata_ff <= nxt_rdata;
			busy_ff <= nxt_busy;
			full_evt_ff <= nxt_full_evt;
			evt_seen_ff <= nxt_evt_seen;
			hdr_seen_ff <= nxt_hdr_seen;
			link_fault_ff <= nxt_link_fault;
			overrun_fault_ff <= nxt_overrun_fault;
			end_missing_fault_ff <= nxt_end_missing_fault;
			header_length_fault_ff <= nxt_header_length_fault;
			eoe_ff <= nxt_eoe;
			hdr_done_ff <= nxt_hdr_done;
			wdog_run_ff <= nxt_wdog_run;
			wdog_cnt_ff <= nxt_wdog_cnt;
			hdr_cnt_ff <= nxt_hdr_cnt;
			ab_ff <= nxt_ab;
			mezz_ff <= nxt_mezz;
			ped_ff <= nxt_ped;
			hdr_serial_en_n_n_ff <= nxt_hdr_serial_en_n_n;
			ser_stb_ff <= nxt_ser_stb;
			lhd_ff <= nxt_lhd;
			mask_ff <= nxt_mask;
			feclr_ff <= frontend_clear_sig;
			fault_n_ff <= nxt_fault_n;
			busy_out_ff <= nxt_busy_out;
			fe_reg_ff <= nxt_fe_reg;
		end
	end

	// Outputs, each from flops; abort pulse and word ready pass through decode logic
	assign bus_rdata_o = rdata_ff;
	assign word_ready_o = fifo_ready;
	assign mezz_bus_o = mezz_ff;
	assign pedestal_strobe_o = ped_ff;
	assign abort_pulse_n_o = ~abort_now;
	assign event_end_n_o = ~eoe_ff;
	assign fault_irq_n_o = fault_n_ff;
	assign event_end_watchdog_n_o = ~end_missing_fault_ff;
	assign frontend_reg_o = fe_reg_ff;
	assign hdr_serial_en_n_o = hdr_serial_en_n_n_ff;
	assign hdr_serial_strobe_o = ser_stb_ff;
	assign latched_header_bus_o = lhd_ff;
	assign header_done_o = hdr_done_ff;
	assign hdr_mask_init_o = mask_ff;
	assign frontend_clear_o = feclr_ff;
	assign drift_mode_line_o = ~mode_ff;
	assign busy_out_o = busy_out_ff;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_clr_one_mezz: assert property (bus_wr_i && bus_addr_i == `RBFE_OFS_CLR1 && !evt_i.evt_end
		|=> !clear_flag_ff[1] && clear_flag_ff[0] == $past(clear_flag_ff[0]))
		else $error("busy clear touched another mezzanine");
	a_auto_feclr: assert property (clear_flag_ff != 3'h0 && nxt_clear_flag == 3'h0 |=> frontend_clear_o)
		else $error("last busy clear did not clear front end");
	a_abort_width: assert property ($fell(abort_pulse_n_o) |=> !abort_pulse_n_o ##1 abort_pulse_n_o)
		else $error("abort pulse not two cycles");
	a_eoe_hold: assert property (!event_end_n_o && !frontend_clear_sig |=> !event_end_n_o)
		else $error("end of event released without clear");
	a_irq_or: assert property (fault_irq_n_o == !(link_fault_ff | overrun_fault_ff | end_missing_fault_ff
		| header_length_fault_ff))
		else $error("fault interrupt not the or of faults");
	a_mode_line: assert property (drift_mode_line_o != mode_ff)
		else $error("mode line not inverse of mode bit");
	a_busy_gate: assert property (!busy_out_on_ff |=> !busy_out_o)
		else $error("busy output active while disabled");
	a_read_gate: assert property (frontend_read_gate_i == `RBFE_GATE_ERR |=> frontend_reg_o == $past(error_byte))
		else $error("read gate did not select errors");
	a_hdr_done: assert property (evt_i.hdr_end |=> header_done_o)
		else $error("header done not set");
	a_wdog_fire: assert property (wdog_run_ff && wdog_cnt_ff == 32'(WDOG_CYCLES - 1) && !evt_i.evt_end
		|=> !event_end_watchdog_n_o)
		else $error("watchdog expiry did not latch");
endmodule : rbfe_regs

`default_nettype wire

// ### sim/rbfe_hdr_mem_model.sv
// Purpose: Header memory sink beside the register bank
// Assumes: A byte is offered with strobe high and enable low in the same cycle
// Notes: pace_i 0 prompt, 1 slow (one cycle in four), 2 stalled
`timescale 1ns/1ns
`default_nettype none
module rbfe_hdr_mem_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Pacing from the bench
	input wire logic [1:0] pace_i,
	// Header memory pins
	input wire logic en_n_i,
	input wire logic strobe_i,
	input wire logic [9:0] data_i,
	output logic ready_o
);
	// ****************
	// Pacing and capture
	// ****************
	logic [9:0] got[$];
	logic [1:0] tick_ff;
	// Slow pace keeps the buffer backed up, so the drain side is really exercised
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_ff <= 2'h0;
			ready_o <= 1'b0;
		end else begin
			tick_ff <= tick_ff + 2'h1;
			ready_o <= (pace_i == 2'h0) || (pace_i == 2'h1 && tick_ff == 2'h0);
		end
	end
	// Store a byte only when enable and strobe agree
	always @(posedge clk_i) begin
		if (strobe_i && !en_n_i) begin
			got.push_back(data_i);
		end
	end
endmodule : rbfe_hdr_mem_model
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench of the receiver front-end register bank
// Assumes: Watchdog shortened to 16 cycles
// Notes: Pulse outputs are tallied, so checks do not hinge on exact pulse cycles
`timescale 1ns/1ns
`include "rbfe_defines.svh"
`default_nettype none
module tb;
	// ****************
	// Signals
	// ****************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic link_rdy = 1'b1;
	logic abort_req = 1'b0;
	logic [1:0] gate = 2'h0;
	logic [1:0] pace = 2'h0;
	rbfe_pkg::rbfe_evt_s evt = '0;
	rbfe_pkg::rbfe_word_s word = '0;
	rbfe_pkg::rbfe_mezz_s [2:0] mezz;
	logic [31:0] rdata;
	logic [7:0] fe_reg;
	logic [9:0] lhd;
	logic [19:0] ped_data;
	logic word_rdy, ped, ab_n, eoe_n, irq_n, wd_n, en_n, strb, done, mask, fc, drift, busy, mem_rdy;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int fc_cnt = 0;
	int pd_cnt = 0;
	int ab_cnt = 0;
	int mk_cnt = 0;
	// Clock at 125 MHz
	always #4 clk = ~clk;
	rbfe_regs #(.WDOG_CYCLES(16), .HDR_DEPTH(8)) u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .bus_addr_i(addr),
		.bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .link_ready_i(link_rdy),
		.evt_i(evt), .word_i(word), .word_ready_o(word_rdy), .abort_req_i(abort_req), .mezz_bus_o(mezz),
		.pedestal_strobe_o(ped), .abort_pulse_n_o(ab_n), .event_end_n_o(eoe_n), .fault_irq_n_o(irq_n),
		.event_end_watchdog_n_o(wd_n), .frontend_read_gate_i(gate), .frontend_reg_o(fe_reg),
		.hdr_mem_ready_i(mem_rdy), .hdr_serial_en_n_o(en_n), .hdr_serial_strobe_o(strb),
		.latched_header_bus_o(lhd), .header_done_o(done), .hdr_mask_init_o(mask), .frontend_clear_o(fc),
		.drift_mode_line_o(drift), .busy_out_o(busy));
	rbfe_hdr_mem_model u_mem (.clk_i(clk), .rst_n_i(rst_n), .pace_i(pace), .en_n_i(en_n), .strobe_i(strb),
		.data_i(lhd), .ready_o(mem_rdy));
	// Tallies start after reset, so only the two post-reset low cycles of the power-up abort count; also the hang limit
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			tally_and_finish();
		end
		if (rst_n) begin
			fc_cnt <= fc_cnt + (fc ? 1 : 0);
			pd_cnt <= pd_cnt + (ped ? 1 : 0);
			ab_cnt <= ab_cnt + (!ab_n ? 1 : 0);
			mk_cnt <= mk_cnt + (mask ? 1 : 0);
			if (ped) ped_data <= mezz[0].data;
		end
	end
	// ****************
	// Helpers
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bw
	// Read data is taken one edge after the read edge, where it has settled
	task automatic br(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		idle(1);
		chk(rdata, exp);
	endtask : br
	task automatic ev(input logic [4:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= '0;
	endtask : ev
	// Offer one header word and hold it until taken or refused for 20 edges
	task automatic send(input int i, output bit ok);
		int k;
		@(posedge clk);
		word <= {1'b1, 1'b1, 2'h0, 3'h0, 20'(i)};
		ok = 1'b0;
		for (k = 0; k < 20 && !ok; k++) begin
			@(posedge clk);
			ok = (word_rdy === 1'b1);
		end
		word <= '0;
	endtask : send
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		br(`RBFE_OFS_MODE, 32'h0000_0000);
		br(`RBFE_OFS_BSYEN, 32'h0000_0000);
		br(`RBFE_OFS_CLR0, 32'h0000_0000);
		br(`RBFE_OFS_LVL0, 32'h0000_0000);
		chk(32'({drift, busy}), 32'h0000_0002);
		chk(32'(ab_cnt), 32'h0000_0002);
		$display("reset test done");
	endtask : t_reset
	task automatic t_mode();
		bw(`RBFE_OFS_MODE, 32'hFFFF_FF01);
		br(`RBFE_OFS_MODE, 32'h0000_0001);
		chk(32'(drift), 32'h0000_0000);
		bw(`RBFE_OFS_MODE, 32'h0000_0000);
		bw(`RBFE_OFS_STAT, 32'h0000_00FF);
		br(8'h3C, 32'h0000_0000);
		chk(32'(drift), 32'h0000_0001);
		bw(`RBFE_OFS_MASK, 32'h0000_007F);
		bw(`RBFE_OFS_MASK, 32'h0000_00FF);
		br(`RBFE_OFS_MASK, 32'h0000_0000);
		chk(32'(mk_cnt), 32'h0000_0001);
		@(posedge clk);
		gate <= 2'h1;
		idle(2);
		chk(32'(fe_reg & 8'hB8), 32'h0000_0080);
		@(posedge clk);
		gate <= 2'h3;
		idle(2);
		chk(32'(fe_reg), 32'h0000_0000);
		@(posedge clk);
		word <= {1'b1, 1'b0, 2'h2, 3'h5, 20'hA_BCDE};
		@(posedge clk);
		word <= '0;
		#1;
		chk(32'(mezz[2]), 32'h0055_E6F5);
		chk(32'(mezz[0]), 32'h0000_0000);
		$display("mode test done");
	endtask : t_mode
	task automatic t_busy();
		int f0;
		f0 = fc_cnt;
		ev(5'h02);
		idle(1);
		chk(32'(eoe_n), 32'h0000_0000);
		br(`RBFE_OFS_CLR1, 32'h0000_0007);
		bw(`RBFE_OFS_CLR1, 32'h0000_0000);
		br(`RBFE_OFS_CLR2, 32'h0000_0005);
		bw(`RBFE_OFS_CLR0, 32'hFFFF_FFFF);
		br(`RBFE_OFS_CLR0, 32'h0000_0004);
		chk(32'(fc_cnt - f0), 32'h0000_0000);
		bw(`RBFE_OFS_CLR2, 32'h0000_0000);
		idle(3);
		chk(32'(fc_cnt - f0), 32'h0000_0001);
		chk(32'(eoe_n), 32'h0000_0001);
		bw(`RBFE_OFS_LVL1, 32'h0000_0002);
		bw(`RBFE_OFS_LVL2, 32'h0000_00FF);
		bw(`RBFE_OFS_LVL0, 32'h0000_00FE);
		br(`RBFE_OFS_LVL0, 32'h0000_0006);
		chk(32'(busy), 32'h0000_0000);
		bw(`RBFE_OFS_BSYEN, 32'h0000_0001);
		idle(2);
		chk(32'(busy), 32'h0000_0001);
		bw(`RBFE_OFS_LVL1, 32'h0000_0000);
		bw(`RBFE_OFS_LVL2, 32'h0000_0000);
		br(`RBFE_OFS_LVL2, 32'h0000_0000);
		chk(32'(busy), 32'h0000_0000);
		bw(`RBFE_OFS_BSYEN, 32'h0000_0000);
		$display("busy test done");
	endtask : t_busy
	task automatic t_wdog();
		ev(5'h02);
		idle(24);
		chk(32'({wd_n, irq_n}), 32'h0000_0000);
		br(`RBFE_OFS_ERR, 32'h0000_0020);
		bw(`RBFE_OFS_FECLR, 32'h0000_0000);
		idle(2);
		chk(32'({wd_n, irq_n, eoe_n}), 32'h0000_0007);
		br(`RBFE_OFS_ERR, 32'h0000_0000);
		bw(`RBFE_OFS_CLR0, 32'h0000_0000);
		bw(`RBFE_OFS_CLR1, 32'h0000_0000);
		bw(`RBFE_OFS_CLR2, 32'h0000_0000);
		$display("watchdog test done");
	endtask : t_wdog
	task automatic t_abort();
		int a0;
		a0 = ab_cnt;
		@(posedge clk);
		link_rdy <= 1'b0;
		abort_req <= 1'b1;
		@(posedge clk);
		abort_req <= 1'b0;
		gate <= 2'h1;
		idle(4);
		chk(32'(ab_cnt - a0), 32'h0000_0000);
		chk(32'(fe_reg[7]), 32'h0000_0000);
		@(posedge clk);
		link_rdy <= 1'b1;
		ev(5'h01);
		idle(2);
		chk(32'(irq_n), 32'h0000_0000);
		br(`RBFE_OFS_ERR, 32'h0000_0080);
		@(posedge clk);
		abort_req <= 1'b1;
		@(posedge clk);
		abort_req <= 1'b0;
		idle(4);
		chk(32'(ab_cnt - a0), 32'h0000_0002);
		chk(32'(irq_n), 32'h0000_0001);
		$display("abort test done");
	endtask : t_abort
	// Fill the buffer against a stalled memory, then drain it; eight bytes make a short header
	task automatic t_fill();
		int n;
		bit ok;
		n = 0;
		@(posedge clk);
		pace <= 2'h2;
		ev(5'h18);
		br(`RBFE_OFS_STAT, 32'h0000_00C3);
		for (int i = 0; i < 10; i++) begin
			send(i, ok);
			n += ok;
		end
		chk(32'(n), 32'h0000_0008);
		chk(32'(word_rdy), 32'h0000_0000);
		@(posedge clk);
		pace <= 2'h1;
		idle(60);
		chk(32'(u_mem.got.size()), 32'h0000_0008);
		chk(32'(word_rdy), 32'h0000_0001);
		ev(5'h0C);
		idle(2);
		br(`RBFE_OFS_ERR, 32'h0000_0050);
		chk(32'(irq_n), 32'h0000_0000);
		bw(`RBFE_OFS_FECLR, 32'h0000_0000);
		idle(2);
		chk(32'(irq_n), 32'h0000_0001);
		$display("fill test done");
	endtask : t_fill
	task automatic t_hdr();
		int p0;
		bit ok;
		p0 = pd_cnt;
		u_mem.got.delete();
		bw(`RBFE_OFS_MODE, 32'h0000_0001);
		ev(5'h10);
		for (int i = 0; i < 64; i++) send(i, ok);
		ev(5'h04);
		idle(60);
		chk(32'(u_mem.got.size()), 32'h0000_0040);
		for (int k = 0; k < u_mem.got.size(); k++) chk(32'(u_mem.got[k]), 32'(k));
		chk(32'(pd_cnt - p0), 32'h0000_0001);
		chk(32'(ped_data), 32'h0000_4010);
		chk(32'(done), 32'h0000_0001);
		br(`RBFE_OFS_ERR, 32'h0000_0000);
		bw(`RBFE_OFS_FECLR, 32'h0000_0000);
		idle(2);
		chk(32'(done), 32'h0000_0000);
		bw(`RBFE_OFS_MODE, 32'h0000_0000);
		$display("header test done");
	endtask : t_hdr
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// Reset for three cycles, then run every scenario
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_mode();
		t_busy();
		t_wdog();
		t_abort();
		t_fill();
		t_hdr();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
